// >>> core/psi_pkg.sv
// Purpose: Shared constants and types for the supply status indicator.
// Assumes: 10 MHz core clock, synchronous active-high reset.
// Notes:   Register offsets are byte addresses on a 32-bit plain port.
package psi_pkg;

    // ***********************************************
    // Timing
    // ***********************************************
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned BLINK_TIME_NS = 500_000_000;
    localparam int unsigned BLINK_CYCLES  = BLINK_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned BLINK_CNT_W   = 23;

    // ***********************************************
    // Register map
    // ***********************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] WARN_OFS = 8'h08;
    localparam int unsigned CTRL_TEST_POS = 0;
    localparam logic CTRL_TEST_RST = 1'b0;

    // ***********************************************
    // Fan comparison
    // ***********************************************
    localparam int unsigned FAN_W = 12;
    // Mismatch when 5 * difference exceeds the faster fan (20 %).
    localparam logic [2:0] FAN_RATIO = 3'h5;

    // ***********************************************
    // Types
    // ***********************************************
    typedef enum logic [1:0] {
        PSI_OFF    = 2'b00,
        PSI_GREEN  = 2'b01,
        PSI_ORANGE = 2'b10,
        PSI_RED    = 2'b11
    } psi_color_e;

    typedef struct packed {
        logic in_present;
        logic in_range;
        logic overvoltage_trip;
        logic ovl;
        logic out_sag;
        logic hiccup_act;
        logic hiccup_on;
        logic ot_warn;
        logic ot_fault;
        logic remote_off;
        logic fans_multi;
    } psi_cond_s;

    localparam int unsigned INFO_W = 8;

    // Output reset values.
    localparam logic RST_FAULT_OK = 1'b1;
    localparam logic RST_OUT_GOOD = 1'b0;
    localparam logic RST_IN_GOOD  = 1'b0;
    localparam logic RST_TEMP_OK  = 1'b1;

endpackage : psi_pkg

// >>> core/psi_status.sv
// Purpose: Front-panel lamp and backplane status logic of a power supply.
// Assumes: Condition pins are asynchronous; fan speeds come from core logic.
// Notes:   All outputs are registered; lamps share one blink phase.
//
// What this block does
// - Fans differing over 20 percent raise a wear-out warning, no shutdown.
// - Information alarms only warn; they never force a shutdown.
// - Input lamp steady green while input is within limits.
// - Output lamp green ok, blinking on running fault, red on shutdown.
// - Output good drops on overload or on input loss.
// - Overload blinks only after output sags; in hiccup only in on-phase.
// - Blink cadence is 0.5 s on and 0.5 s off.
// - Normal operation: both lamps green, all monitors high.
// - Input out of range: input lamp blinks, input good pulses.
// - Overcurrent: output lamp blinks, output good low, others high.
// - Over-temperature warning: orange blink, temperature good pulses.
// - Over-temperature fault: red lamp, fault, output and temp good low.
// - External faults never assert the fault output.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module psi_status #(
    parameter int unsigned BLINK_CYC = psi_pkg::BLINK_CYCLES
) (
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire psi_pkg::psi_cond_s          cond_pins,
    input  wire logic [psi_pkg::INFO_W-1:0]  info_pins,
    input  wire logic [psi_pkg::FAN_W-1:0]   fan_speed_a,
    input  wire logic [psi_pkg::FAN_W-1:0]   fan_speed_b,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [31:0]                      reg_rdata,
    output logic                             input_status_lamp,
    output psi_pkg::psi_color_e              output_status_lamp,
    output logic                             fault_ok,
    output logic                             output_good,
    output logic                             input_good,
    output logic                             temp_good,
    output logic                             warn_flag
);
    import psi_pkg::*;

    // ***********************************************
    // Pin synchronisers
    // ***********************************************
    psi_cond_s          c_s1_ff;
    psi_cond_s          c;
    logic [INFO_W-1:0]  info_s1_ff;
    logic [INFO_W-1:0]  info_ff;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            c_s1_ff    <= '0;
            c          <= '0;
            info_s1_ff <= '0;
            info_ff    <= '0;
        end else begin
            c_s1_ff    <= cond_pins;
            c          <= c_s1_ff;
            info_s1_ff <= info_pins;
            info_ff    <= info_s1_ff;
        end
    end

    // ***********************************************
    // Blink timer
    // ***********************************************
    logic [BLINK_CNT_W-1:0] cnt_ff;
    logic                   blink_ph_ff;
    wire                    tick = (cnt_ff == BLINK_CNT_W'(BLINK_CYC - 1));
    wire [BLINK_CNT_W-1:0]  nxt_cnt = tick ? '0 : cnt_ff + 1'b1;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_ff      <= '0;
            blink_ph_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            if (tick) begin
                blink_ph_ff <= ~blink_ph_ff;
            end
        end
    end

    // ***********************************************
    // Register port
    // ***********************************************
    logic        test_ff;
    psi_color_e  test_col_ff;
    logic [31:0] rdata_ff;

    wire wr_ctrl = reg_wr && (reg_addr == CTRL_OFS);

    // Lamp test walks green, orange, red, one color per blink period.
    wire psi_color_e nxt_test_col =
        (test_col_ff == PSI_RED || test_col_ff == PSI_OFF) ? PSI_GREEN :
        (test_col_ff == PSI_GREEN) ? PSI_ORANGE : PSI_RED;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            test_ff     <= CTRL_TEST_RST;
            test_col_ff <= PSI_GREEN;
        end else begin
            if (wr_ctrl) begin
                test_ff <= reg_wdata[CTRL_TEST_POS];
            end
            if (!test_ff) begin
                test_col_ff <= PSI_GREEN;
            end else if (tick && blink_ph_ff) begin
                test_col_ff <= nxt_test_col;
            end
        end
    end

    logic fan_mis_ff;

    wire [31:0] stat_word = {17'h0, c, input_status_lamp,
                             fault_ok, output_good, input_good};
    wire [31:0] warn_word = {22'h0, fan_mis_ff, warn_flag, info_ff};
    wire [31:0] nxt_rdata =
        !reg_rd                ? 32'h0 :
        (reg_addr == CTRL_OFS) ? {31'h0, test_ff} :
        (reg_addr == STAT_OFS) ? stat_word :
        (reg_addr == WARN_OFS) ? warn_word : 32'h0;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ***********************************************
    // Fan mismatch
    // ***********************************************
    wire              a_big  = fan_speed_a >= fan_speed_b;
    wire [FAN_W-1:0]  f_max  = a_big ? fan_speed_a : fan_speed_b;
    wire [FAN_W-1:0]  f_diff = a_big ? fan_speed_a - fan_speed_b
                                     : fan_speed_b - fan_speed_a;
    wire [FAN_W+2:0]  f_scl  = (FAN_W+3)'(f_diff) * (FAN_W+3)'(FAN_RATIO);
    wire nxt_fan_mis = c.fans_multi && (f_scl > (FAN_W+3)'(f_max));

    // ***********************************************
    // Indication decode
    // ***********************************************
    wire ph      = blink_ph_ff;
    wire in_ok   = c.in_present && c.in_range;
    wire shut    = c.overvoltage_trip || c.ot_fault;
    wire ovl_blk = c.ovl && c.out_sag && (!c.hiccup_act || c.hiccup_on);
    wire ovl_dark = c.ovl && c.hiccup_act && !c.hiccup_on;

    wire nxt_in_lamp = test_ff ? ph :
                       !c.in_present ? 1'b0 :
                       c.in_range ? 1'b1 : ph;

    wire psi_color_e nxt_out_lamp =
        test_ff        ? (ph ? test_col_ff : PSI_OFF) :
        !c.in_present  ? PSI_OFF :
        shut           ? PSI_RED :
        ovl_blk        ? (ph ? PSI_GREEN : PSI_OFF) :
        c.ot_warn      ? (ph ? PSI_ORANGE : PSI_OFF) :
        (c.remote_off || ovl_dark) ? PSI_OFF : PSI_GREEN;

    wire nxt_fault_ok = !shut;
    wire nxt_out_good = in_ok && !shut && !c.ovl && !c.remote_off;
    wire nxt_in_good  = c.in_present && (c.in_range || ph);
    wire nxt_temp_ok  = !c.ot_fault && (!c.ot_warn || ph);
    wire nxt_warn     = (|info_ff) || c.ot_warn || fan_mis_ff;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            input_status_lamp  <= 1'b0;
            output_status_lamp <= PSI_OFF;
            fault_ok           <= RST_FAULT_OK;
            output_good        <= RST_OUT_GOOD;
            input_good         <= RST_IN_GOOD;
            temp_good          <= RST_TEMP_OK;
            warn_flag          <= 1'b0;
            fan_mis_ff         <= 1'b0;
        end else begin
            input_status_lamp  <= nxt_in_lamp;
            output_status_lamp <= nxt_out_lamp;
            fault_ok           <= nxt_fault_ok;
            output_good        <= nxt_out_good;
            input_good         <= nxt_in_good;
            temp_good          <= nxt_temp_ok;
            warn_flag          <= nxt_warn;
            fan_mis_ff         <= nxt_fan_mis;
        end
    end

    // ***********************************************
    // Assertions
    // ***********************************************
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    wire normal = in_ok && !shut && !c.ovl && !c.ot_warn && !c.remote_off;

    blink_period_a: assert property ($changed(blink_ph_ff) |-> $past(tick))
        else $error("blink phase moved off the half-period tick");

    blink_count_a: assert property (cnt_ff <= BLINK_CNT_W'(BLINK_CYC - 1))
        else $error("blink counter ran past its wrap value");

    normal_lamps_a: assert property (normal && !test_ff |=>
        output_status_lamp == PSI_GREEN && input_status_lamp && fault_ok
        && output_good && input_good && temp_good)
        else $error("normal operation indication wrong");

    no_input_a: assert property (!c.in_present && !test_ff |=>
        output_status_lamp == PSI_OFF && !input_status_lamp
        && !output_good && !input_good)
        else $error("no-input indication wrong");

    red_first_a: assert property (c.in_present && shut && !test_ff |=>
        output_status_lamp == PSI_RED && !fault_ok && !output_good)
        else $error("shutdown did not show red");

    ext_fault_a: assert property (!shut |=> fault_ok)
        else $error("fault output asserted for external fault");

    ovl_sag_a: assert property (in_ok && c.ovl && !c.out_sag && !shut
        && !c.ot_warn && !c.remote_off && !c.hiccup_act && !test_ff
        |=> output_status_lamp == PSI_GREEN && !output_good)
        else $error("overload blinked before output sagged");

    ovl_blink_a: assert property (in_ok && ovl_blk && !shut && !test_ff
        |=> output_status_lamp == ($past(ph) ? PSI_GREEN : PSI_OFF)
        && !output_good && fault_ok && input_good)
        else $error("overcurrent indication wrong");

    temp_pulse_a: assert property (c.ot_warn && !shut
        |=> temp_good == $past(ph) && fault_ok)
        else $error("temperature good did not follow blink");

    in_pulse_a: assert property (c.in_present && !c.in_range && !test_ff
        |=> input_good == $past(ph) && input_status_lamp == $past(ph))
        else $error("out-of-range input indication wrong");

    remote_off_a: assert property (in_ok && c.remote_off && !shut && !c.ovl
        && !c.ot_warn && !test_ff |=> output_status_lamp == PSI_OFF
        && !output_good && fault_ok && input_good)
        else $error("remote off indication wrong");

    fan_warn_a: assert property (fan_mis_ff |=> warn_flag && fault_ok == $past(!shut))
        else $error("fan mismatch did not warn");

    ovp_trip_a: assert property (in_ok && c.overvoltage_trip && !test_ff |=>
        input_status_lamp && output_status_lamp == PSI_RED
        && !fault_ok && !output_good && input_good)
        else $error("overvoltage indication wrong");

    ot_fault_a: assert property (c.in_present && c.ot_fault && !test_ff |=>
        output_status_lamp == PSI_RED && !fault_ok && !output_good && !temp_good)
        else $error("over-temperature fault indication wrong");

    in_lamp_a: assert property (in_ok && !test_ff |=> input_status_lamp)
        else $error("input lamp not steady green");

    info_warn_a: assert property ((|info_ff) && normal && !test_ff |=>
        warn_flag && output_good && output_status_lamp == PSI_GREEN)
        else $error("information alarm caused more than a warning");

    cov_overload_c:  cover property (c.ovl ##1 ovl_blk);
    cov_ot_warn_c:   cover property (c.ot_warn && tick);
    cov_lamp_test_c: cover property (test_ff && test_col_ff == PSI_RED);
    cov_fan_c:       cover property ($rose(fan_mis_ff));

endmodule : psi_status

// >>> dv/psi_host_model.sv
// Purpose: Model of the system controller that samples the input good and temperature good outputs.
// Assumes: Outputs are sampled on every rising clock edge.
// Notes:   Pulsing outputs are judged by how many samples found them high.
`timescale 1ns/1ps
module psi_host_model (
    input  wire logic ref_clk,
    input  wire logic clr,
    input  wire logic input_good,
    input  wire logic temp_good,
    output int        cnt_ig,
    output int        cnt_tg
);
    // A count rather than an edge log, so a stuck or unknown level cannot pass as a pulse.
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            cnt_ig <= 0;
            cnt_tg <= 0;
        end else begin
            cnt_ig <= cnt_ig + ((input_good === 1'b1) ? 1 : 0);
            cnt_tg <= cnt_tg + ((temp_good === 1'b1) ? 1 : 0);
        end
    end
endmodule : psi_host_model

// >>> dv/test_psi_status.sv
// Purpose: Self-checking bench for the supply status indicator.
// Assumes: Blink half period shortened to 8 clocks.
// Notes:   Levels are counted over two full blink periods, so a blink shows as 16.
`timescale 1ns/1ps
module test_psi_status;
    import psi_pkg::*;
    localparam int unsigned BLINK = 8;
    logic              ref_clk = 1'b0;
    logic              sys_rst = 1'b1;
    psi_cond_s         cond_pins = '0;
    logic [INFO_W-1:0] info_pins = '0;
    logic [FAN_W-1:0]  fan_a = '0;
    logic [FAN_W-1:0]  fan_b = '0;
    logic [7:0]        reg_addr = '0;
    logic [31:0]       reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic              clr = 1'b0;
    logic [31:0]       reg_rdata;
    logic              in_lamp, fault_ok, output_good, input_good, temp_good, warn_flag;
    psi_color_e        out_lamp;
    int                cnt_ig, cnt_tg, n_in, n_fok, n_og, n_warn, n_x;
    int                n_col[4];
    int                num_errors = 0;
    int                total_checks = 0;

    psi_status #(.BLINK_CYC(BLINK)) u_psi_status (.ref_clk(ref_clk), .sys_rst(sys_rst), .cond_pins(cond_pins),
        .info_pins(info_pins), .fan_speed_a(fan_a), .fan_speed_b(fan_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .input_status_lamp(in_lamp), .output_status_lamp(out_lamp), .fault_ok(fault_ok),
        .output_good(output_good), .input_good(input_good), .temp_good(temp_good), .warn_flag(warn_flag));
    psi_host_model u_psi_host_model (.ref_clk(ref_clk), .clr(clr), .input_good(input_good),
        .temp_good(temp_good), .cnt_ig(cnt_ig), .cnt_tg(cnt_tg));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // ***********************************************
    // Compare and report
    // ***********************************************
    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic check_count(string what, int exp, int got);
        total_checks++;
        if (exp != got) begin
            num_errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_count

    task automatic check_word(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    // ***********************************************
    // Drivers
    // ***********************************************
    task automatic reg_write(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand for one cycle only, so the idle cycle after is checked too.
    task automatic reg_read(logic [7:0] a, logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        check_word("reg_rdata", exp, reg_rdata);
        @(negedge ref_clk);
        check_word("reg_rdata_idle", 32'h0, reg_rdata);
    endtask : reg_read

    // Pins are synchronised, so allow the pipeline to fill before counting.
    task automatic observe(logic [10:0] c);
        @(posedge ref_clk);
        cond_pins <= psi_cond_s'(c);
        repeat (6) @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        n_in   = 0;
        n_fok  = 0;
        n_og   = 0;
        n_warn = 0;
        n_x    = 0;
        n_col  = '{0, 0, 0, 0};
        repeat (4 * BLINK) begin
            @(negedge ref_clk);
            n_in   += (in_lamp === 1'b1);
            n_fok  += (fault_ok === 1'b1);
            n_og   += (output_good === 1'b1);
            n_warn += (warn_flag === 1'b1);
            n_x    += $isunknown({in_lamp, out_lamp, fault_ok, output_good, input_good, temp_good, warn_flag});
            if (!$isunknown(out_lamp)) n_col[out_lamp]++;
        end
        @(posedge ref_clk);
        #1;
    endtask : observe

    task automatic expect_all(int lin, int g, int o, int r, int fk, int og, int ig, int tg);
        check_count("input_status_lamp", lin, n_in);
        check_count("lamp_green", g, n_col[1]);
        check_count("lamp_orange", o, n_col[2]);
        check_count("lamp_red", r, n_col[3]);
        check_count("fault_ok", fk, n_fok);
        check_count("output_good", og, n_og);
        check_count("input_good", ig, cnt_ig);
        check_count("temp_good", tg, cnt_tg);
        check_count("unknown_levels", 0, n_x);
    endtask : expect_all

    // ***********************************************
    // Scenarios
    // ***********************************************
    task automatic sc_states();
        observe(11'h600);
        expect_all(32, 32, 0, 0, 32, 32, 32, 32);
        check_count("warn_flag", 0, n_warn);
        observe(11'h400);
        expect_all(16, 32, 0, 0, 32, 0, 16, 32);
        observe(11'h000);
        expect_all(0, 0, 0, 0, 32, 0, 0, 32);
        observe(11'h700);
        expect_all(32, 0, 0, 32, 0, 0, 32, 32);
        observe(11'h604);
        expect_all(32, 0, 0, 32, 0, 0, 32, 0);
        observe(11'h602);
        expect_all(32, 0, 0, 0, 32, 0, 32, 32);
        observe(11'h608);
        expect_all(32, 0, 16, 0, 32, 32, 32, 16);
        check_count("warn_flag", 32, n_warn);
    endtask : sc_states

    task automatic sc_overload();
        observe(11'h680);
        expect_all(32, 32, 0, 0, 32, 0, 32, 32);
        observe(11'h6C0);
        expect_all(32, 16, 0, 0, 32, 0, 32, 32);
        observe(11'h6E0);
        expect_all(32, 0, 0, 0, 32, 0, 32, 32);
        observe(11'h6F0);
        expect_all(32, 16, 0, 0, 32, 0, 32, 32);
    endtask : sc_overload

    task automatic sc_priority();
        observe(11'h7C0);
        expect_all(32, 0, 0, 32, 0, 0, 32, 32);
        observe(11'h6C8);
        expect_all(32, 16, 0, 0, 32, 0, 32, 16);
        observe(11'h6C2);
        expect_all(32, 16, 0, 0, 32, 0, 32, 32);
    endtask : sc_priority

    task automatic sc_warnings();
        info_pins <= 8'hFF;
        observe(11'h600);
        expect_all(32, 32, 0, 0, 32, 32, 32, 32);
        check_count("warn_flag", 32, n_warn);
        info_pins <= 8'h00;
        fan_a     <= 12'h064;
        fan_b     <= 12'h050;
        observe(11'h601);
        check_count("warn_flag", 0, n_warn);
        fan_b <= 12'h04F;
        observe(11'h601);
        check_count("warn_flag", 32, n_warn);
        expect_all(32, 32, 0, 0, 32, 32, 32, 32);
        observe(11'h600);
        check_count("warn_flag", 0, n_warn);
    endtask : sc_warnings

    // Lamp test blinks both lamps but must leave the monitor outputs alone.
    task automatic sc_registers();
        reg_read(STAT_OFS, 32'h0000600F);
        reg_read(8'h0C, 32'h00000000);
        reg_write(CTRL_OFS, 32'h00000001);
        reg_read(CTRL_OFS, 32'h00000001);
        observe(11'h600);
        check_count("input_status_lamp", 16, n_in);
        check_count("lamp_off", 16, n_col[0]);
        check_count("output_good", 32, n_og);
        reg_write(CTRL_OFS, 32'h00000000);
        reg_read(CTRL_OFS, 32'h00000000);
    endtask : sc_registers

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        check_word("output_good", 32'h0, {31'h0, output_good});
        check_word("fault_ok", 32'h1, {31'h0, fault_ok});
        check_word("reset_lamps", 32'h0, {29'h0, in_lamp, out_lamp});
        check_word("reset_monitors", 32'h2, {29'h0, input_good, temp_good, warn_flag});
        check_word("reset_rdata", 32'h0, reg_rdata);
        sys_rst <= 1'b0;
        sc_states();
        sc_overload();
        sc_priority();
        sc_warnings();
        sc_registers();
        give_verdict();
    end
endmodule : test_psi_status
